// ===== inc/eepec_pkg.sv
// constants and types for the eeprom program and erase controller
`default_nettype none
package eepec_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MCR = 8'h04;
  localparam logic [7:0] OFF_DIVH = 8'h08;
  localparam logic [7:0] OFF_DIVL = 8'h0c;
  localparam logic [7:0] OFF_PROT = 8'h10;
  localparam logic [7:0] OFF_ADDR = 8'h14;
  localparam logic [7:0] OFF_DATA = 8'h18;
  // control field positions
  localparam int B_PGM = 0;
  localparam int B_LAT = 1;
  localparam int B_ERASE = 2;
  localparam int B_ROW = 3;
  localparam int B_BYTE = 4;
  localparam int B_AUTO = 5;
  localparam int B_BUSY = 8;
  // module config and protection register fields
  localparam int B_DBG = 7;
  localparam int B_HIDE = 6;
  localparam int B_SHADOW_PROTECT = 0;
  localparam int B_ARRPROT = 1;
  // array geometry
  localparam int ARR_W = 12;
  localparam int ARR_D = 4096;
  localparam int ROW_W = 5;
  localparam logic [11:0] SHADOW_HI = 12'h0fc0;
  localparam logic [11:0] SHADOW_LO = 12'h0fc1;
  localparam logic [11:0] ARR_LAST = 12'h0fff;
  localparam logic [7:0] ERASED = 8'hff;
  // reset values and the mcr low nibble that is always zero
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [1:0] DIVH_RST = 2'h0;
  localparam logic [7:0] DIVL_RST = 8'h00;
  localparam logic [3:0] MCR_LOW_ZERO = 4'h0;
  // timing in divided clock ticks
  localparam logic [15:0] PROG_TICKS = 16'h000a;
  localparam logic [15:0] ERASE_TICKS = 16'h0014;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic auto_done;
    logic byte_sel;
    logic row_sel;
    logic erase;
    logic latch_enable;
    logic program_enable;
  } eepec_ctrl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_TIME, ST_APPLY, ST_HOLD} eepec_state_t;
endpackage
`default_nettype wire

// ===== verilog/eepec_top.sv
// eeprom program/erase sequencer with shadow word and axi4-lite registers
`timescale 1ns/1ps
`default_nettype none

module eepec_top import eepec_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic special_mode_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic debug_disable
);
  // nonvolatile storage, kept across reset
  logic [7:0] mem [0:ARR_D-1] = '{default: ERASED};
  logic [7:0] shadow_hi_ff = ERASED;
  logic [7:0] shadow_lo_ff = ERASED;

  function automatic logic is_shadow(input logic [11:0] a);
    is_shadow = (a[11:1] == SHADOW_HI[11:1]);
  endfunction

  // ==========================================================
  // bus slave
  logic aw_full_ff, w_full_ff, bvalid_ff, awready_ff, wready_ff;
  logic rvalid_ff, arready_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rd_val;
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire nxt_aw_full = (aw_full_ff | aw_hs) & ~wr_fire;
  wire nxt_w_full = (w_full_ff | w_hs) & ~wr_fire;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
  wire b_lane = w_strb_ff[0];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CTRL) | (a == OFF_MCR) | (a == OFF_DIVH) | (a == OFF_DIVL) |
             (a == OFF_PROT) | (a == OFF_ADDR) | (a == OFF_DATA);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= ~nxt_aw_full;
      wready_ff <= ~nxt_w_full;
      if (aw_hs) aw_addr_ff <= s_axi_awaddr;
      if (w_hs) w_data_ff <= s_axi_wdata;
      if (w_hs) w_strb_ff <= s_axi_wstrb;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      rvalid_ff <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) rdata_ff <= rd_val;
      if (ar_hs) rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================================
  // registers
  eepec_ctrl_t ctrl_ff;
  logic [7:0] mcr_ff, divl_ff, lat_data_hi_ff, lat_data_lo_ff;
  logic [1:0] divh_ff;
  logic divh_lock_ff, divl_lock_ff, shadow_protect_ff, arrprot_ff, load_ff;
  logic [11:0] eaddr_ff, lat_addr_ff, walk_ff, walk_end_ff;
  logic lat_word_ff, lat_valid_ff;
  eepec_state_t state_ff;
  logic [9:0] pre_ff;
  logic [15:0] tcnt_ff;
  wire [9:0] div_val = {divh_ff, divl_ff};
  wire hide = mcr_ff[B_HIDE];
  wire we_ctrl = wr_fire & b_lane & (aw_addr_ff == OFF_CTRL);
  wire we_mcr = wr_fire & b_lane & (aw_addr_ff == OFF_MCR);
  wire we_divh = wr_fire & b_lane & (aw_addr_ff == OFF_DIVH);
  wire we_divl = wr_fire & b_lane & (aw_addr_ff == OFF_DIVL);
  wire we_prot = wr_fire & b_lane & (aw_addr_ff == OFF_PROT);
  wire we_addr = wr_fire & (aw_addr_ff == OFF_ADDR);
  wire we_data = wr_fire & b_lane & (aw_addr_ff == OFF_DATA);
  wire [31:0] wd = w_data_ff;
  wire bulk = ctrl_ff.erase & ~ctrl_ff.byte_sel & ~ctrl_ff.row_sel;
  wire prot_hit = arrprot_ff | (shadow_protect_ff & is_shadow(lat_addr_ff) & ~bulk);
  wire tick = (pre_ff == div_val);
  wire [15:0] t_limit = ctrl_ff.erase ? ERASE_TICKS : PROG_TICKS;
  wire walk_last = (walk_ff == walk_end_ff);
  wire auto_clear = (state_ff == ST_APPLY) & walk_last & ctrl_ff.auto_done;
  wire start = (state_ff == ST_IDLE) & ctrl_ff.program_enable & (lat_valid_ff | bulk) & ~prot_hit;
  wire [7:0] rd_byte = (is_shadow(eaddr_ff) & ~hide) ? (eaddr_ff[0] ? shadow_lo_ff : shadow_hi_ff) :
                       mem[eaddr_ff];
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFF_CTRL: rd_val = {23'h0, state_ff != ST_IDLE, 2'b00, ctrl_ff};
      OFF_MCR: rd_val = {24'h0, mcr_ff};
      OFF_DIVH: rd_val = {30'h0, divh_ff};
      OFF_DIVL: rd_val = {24'h0, divl_ff};
      OFF_PROT: rd_val = {30'h0, arrprot_ff, shadow_protect_ff};
      OFF_ADDR: rd_val = {20'h0, eaddr_ff};
      OFF_DATA: rd_val = {24'h0, rd_byte};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // control bits
  logic lat_ok;
  assign lat_ok = (div_val != 10'h000);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= '0;
    end else begin
      if (we_ctrl && !ctrl_ff.program_enable) begin
        ctrl_ff.auto_done <= wd[B_AUTO];
        ctrl_ff.byte_sel <= wd[B_BYTE];
        ctrl_ff.row_sel <= wd[B_ROW];
        ctrl_ff.erase <= wd[B_ERASE];
        if (lat_ok) ctrl_ff.latch_enable <= wd[B_LAT];
        ctrl_ff.program_enable <= wd[B_PGM] & wd[B_LAT] & ctrl_ff.latch_enable;
      end else if (we_ctrl && !wd[B_PGM]) begin
        ctrl_ff.program_enable <= 1'b0;
      end
      if (auto_clear) ctrl_ff.program_enable <= 1'b0;
    end
  end

  // config, divider, protection, shadow load after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_ff <= 1'b1;
      mcr_ff <= MCR_RST;
      divh_ff <= DIVH_RST;
      divl_ff <= DIVL_RST;
      divh_lock_ff <= 1'b0;
      divl_lock_ff <= 1'b0;
      shadow_protect_ff <= 1'b1;
      arrprot_ff <= 1'b0;
      eaddr_ff <= 12'h000;
    end else begin
      load_ff <= 1'b0;
      if (load_ff) begin
        mcr_ff <= {shadow_hi_ff[7:4], MCR_LOW_ZERO};
        divh_ff <= shadow_hi_ff[1:0];
        divl_ff <= shadow_lo_ff;
      end else begin
        if (we_mcr) mcr_ff <= {wd[7:4], MCR_LOW_ZERO};
        // special mode may always rewrite the divider, normal mode only once
        if (we_divh && (!divh_lock_ff || !special_mode_n)) divh_ff <= wd[1:0];
        if (we_divl && (!divl_lock_ff || !special_mode_n)) divl_ff <= wd[7:0];
      end
      if (we_divh && special_mode_n) divh_lock_ff <= 1'b1;
      if (we_divl && special_mode_n) divl_lock_ff <= 1'b1;
      if (we_prot) shadow_protect_ff <= wd[B_SHADOW_PROTECT];
      if (we_prot) arrprot_ff <= wd[B_ARRPROT];
      if (we_addr) eaddr_ff <= wd[11:0];
    end
  end

  // data latches for the array write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_addr_ff <= 12'h000;
      lat_data_hi_ff <= 8'h00;
      lat_data_lo_ff <= 8'h00;
      lat_word_ff <= 1'b0;
      lat_valid_ff <= 1'b0;
    end else if (we_data && ctrl_ff.latch_enable && !ctrl_ff.program_enable) begin
      lat_word_ff <= w_strb_ff[1];
      lat_addr_ff <= {eaddr_ff[11:1], eaddr_ff[0] & ~w_strb_ff[1]};
      lat_data_hi_ff <= wd[15:8];
      lat_data_lo_ff <= wd[7:0];
      lat_valid_ff <= 1'b1;
    end else if (!ctrl_ff.latch_enable) begin
      lat_valid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  wire [7:0] apply_val = ctrl_ff.erase ? ERASED :
                         (lat_word_ff & ~walk_ff[0]) ? lat_data_hi_ff : lat_data_lo_ff;
  wire to_shadow = is_shadow(walk_ff) & ~hide & ~shadow_protect_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      pre_ff <= 10'h000;
      tcnt_ff <= 16'h0000;
      walk_ff <= 12'h000;
      walk_end_ff <= 12'h000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          pre_ff <= 10'h000;
          tcnt_ff <= 16'h0000;
          if (start) state_ff <= ST_TIME;
        end
        ST_TIME: begin
          pre_ff <= tick ? 10'h000 : pre_ff + 10'h001;
          if (tick) tcnt_ff <= tcnt_ff + 16'h0001;
          if (!ctrl_ff.program_enable) begin
            state_ff <= ST_IDLE;
          end else if (tick && tcnt_ff == t_limit - 16'h0001) begin
            state_ff <= ST_APPLY;
            if (bulk) begin
              walk_ff <= 12'h000;
              walk_end_ff <= ARR_LAST;
            end else if (ctrl_ff.erase && !ctrl_ff.byte_sel) begin
              walk_ff <= {lat_addr_ff[11:ROW_W], 5'h00};
              walk_end_ff <= {lat_addr_ff[11:ROW_W], 5'h1f};
            end else begin
              walk_ff <= lat_addr_ff;
              walk_end_ff <= {lat_addr_ff[11:1], lat_addr_ff[0] | lat_word_ff};
            end
          end
        end
        ST_APPLY: begin
          walk_ff <= walk_ff + 12'h001;
          if (walk_last) state_ff <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!ctrl_ff.program_enable) state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // array and shadow update
  always_ff @(posedge aclk) begin
    if (state_ff == ST_APPLY) begin
      if (to_shadow && !walk_ff[0]) shadow_hi_ff <= apply_val;
      if (to_shadow && walk_ff[0]) shadow_lo_ff <= apply_val;
      if (!is_shadow(walk_ff) || hide) mem[walk_ff] <= apply_val;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign debug_disable = mcr_ff[B_DBG];

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_pgm_held;
    ctrl_ff.program_enable ##1 ctrl_ff.program_enable;
  endsequence
  a_pgm_needs_latch: assert property ($rose(ctrl_ff.program_enable) |-> $past(ctrl_ff.latch_enable))
    else $error("program enable set without prior latch");
  a_prot_no_start: assert property (state_ff == ST_IDLE && ctrl_ff.program_enable && prot_hit
    |=> state_ff == ST_IDLE) else $error("sequencer started on protected location");
  a_auto_clears: assert property (auto_clear |=> !ctrl_ff.program_enable && state_ff == ST_HOLD)
    else $error("auto completion did not clear program enable");
  a_modes_frozen: assert property (s_pgm_held |-> $stable(ctrl_ff[5:1]))
    else $error("mode bits changed while programming");
  a_latch_frozen: assert property (s_pgm_held |-> $stable(lat_addr_ff) && $stable(lat_data_lo_ff))
    else $error("latched address or data changed while programming");
  a_divl_once: assert property (special_mode_n && divl_lock_ff && !load_ff |=> $stable(divl_ff))
    else $error("locked divider low overwritten");
  a_shadow_load: assert property (load_ff && aresetn |=> divl_ff == $past(shadow_lo_ff)
    && mcr_ff[7:4] == $past(shadow_hi_ff[7:4]) && divh_ff == $past(shadow_hi_ff[1:0]))
    else $error("shadow word not copied after reset");
  a_hidden_shadow: assert property (state_ff == ST_APPLY && hide |=> $stable(shadow_hi_ff)
    && $stable(shadow_lo_ff)) else $error("hidden shadow word was written");
  a_time_min: assert property ($rose(state_ff == ST_TIME) |-> (state_ff != ST_APPLY)[*2])
    else $error("program time shorter than two cycles");
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the eeprom program/erase controller
`timescale 1ns/1ps
`default_nettype none
module tb_top import eepec_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic special_mode_n = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, debug_disable;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp, rrsp;
  logic [31:0] s_axi_rdata, rdat;
  logic clr;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;

  eepec_top u_eepec_top (.aclk(aclk), .aresetn(aresetn), .special_mode_n(special_mode_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .debug_disable(debug_disable));

  always #4 aclk = ~aclk;

  // ==========================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    logic pa, pw, ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do begin
      @(negedge aclk);
      tb = s_axi_bvalid;
      last_resp = s_axi_bresp;
      @(posedge aclk);
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask

  // polls control until program enable drops, at most lim reads
  task automatic poll(input int lim, output logic c);
    int n;
    c = 1'b0;
    for (n = 0; n < lim && !c; n++) begin
      rd(OFF_CTRL);
      c = (rdat[B_PGM] === 1'b0);
    end
  endtask

  // latch, load one byte or word, enable, then poll
  task automatic op(input logic [7:0] m, input logic [11:0] a, input logic [15:0] d,
      input logic [3:0] s, output logic c);
    wr(OFF_CTRL, {24'h00_0000, m | 8'h02});
    wr(OFF_ADDR, {20'h0_0000, a});
    wr(OFF_DATA, {16'h0000, d}, s);
    wr(OFF_CTRL, {24'h00_0000, m | 8'h03});
    poll(50, c);
  endtask

  task automatic rd_arr(input logic [11:0] a, input logic [7:0] e);
    wr(OFF_ADDR, {20'h0_0000, a});
    rd(OFF_DATA);
    chk(rdat, {24'h00_0000, e});
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ==========================================
  // tests
  initial begin
    do_reset();
    rd(OFF_MCR);
    chk(rdat, 32'h0000_00f0);
    rd(OFF_DIVH);
    chk(rdat, 32'h0000_0003);
    rd(OFF_DIVL);
    chk(rdat, 32'h0000_00ff);
    chk(32'(debug_disable), 32'h0000_0001);
    wr(OFF_DIVH, 32'h0000_0000);
    wr(OFF_DIVL, 32'h0000_0001);
    wr(OFF_DIVL, 32'h0000_0009);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(OFF_DIVL);
    chk(rdat, 32'h0000_0001);
    wr(8'h1c, 32'h0000_00ff);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    rd(8'h40);
    chk({rdat[29:0], rrsp}, 32'(RESP_SLVERR));
    $display("test reset and divider done");
    wr(OFF_CTRL, 32'h0000_0003);
    rd(OFF_CTRL);
    chk(rdat, 32'h0000_0002);
    wr(OFF_ADDR, 32'h0000_0010);
    wr(OFF_DATA, 32'h0000_005a);
    wr(OFF_CTRL, 32'h0000_0003);
    wr(OFF_DATA, 32'h0000_0011);
    wr(OFF_CTRL, 32'h0000_0007);
    rd(OFF_CTRL);
    chk({23'h00_0000, rdat[8:0]}, 32'h0000_0103);
    // ten ticks of two cycles each, with margin
    repeat (60) @(posedge aclk);
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0000);
    rd_arr(12'h010, 8'h5a);
    $display("test manual program done");
    op(8'h20, 12'h020, 16'h00a5, 4'h1, clr);
    chk(32'(clr), 32'h0000_0001);
    wr(OFF_ADDR, 32'h0000_0021);
    wr(OFF_DATA, 32'h0000_003c);
    wr(OFF_CTRL, 32'h0000_0023);
    poll(50, clr);
    chk(32'(clr), 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    rd_arr(12'h020, 8'ha5);
    rd_arr(12'h021, 8'h3c);
    op(8'h34, 12'h020, 16'h0000, 4'h1, clr);
    chk(32'(clr), 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    rd_arr(12'h020, 8'hff);
    rd_arr(12'h021, 8'h3c);
    op(8'h2c, 12'h025, 16'h0000, 4'h1, clr);
    chk(32'(clr), 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    rd_arr(12'h021, 8'hff);
    rd_arr(12'h010, 8'h5a);
    wr(OFF_CTRL, 32'h0000_0026);
    wr(OFF_CTRL, 32'h0000_0027);
    poll(2000, clr);
    chk(32'(clr), 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    rd_arr(12'h010, 8'hff);
    $display("test auto chain and erase done");
    wr(OFF_PROT, 32'h0000_0003);
    op(8'h20, 12'h030, 16'h0077, 4'h1, clr);
    chk(32'(clr), 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0022);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_PROT, 32'h0000_0001);
    rd_arr(12'h030, 8'hff);
    $display("test protected location done");
    special_mode_n <= 1'b0;
    wr(OFF_DIVL, 32'h0000_0002);
    rd(OFF_DIVL);
    chk(rdat, 32'h0000_0002);
    wr(OFF_DIVL, 32'h0000_0001);
    rd(OFF_DIVL);
    chk(rdat, 32'h0000_0001);
    wr(OFF_PROT, 32'h0000_0000);
    wr(OFF_MCR, 32'h0000_00b0);
    op(8'h20, 12'hfc0, 16'hfc01, 4'h3, clr);
    chk(32'(clr), 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_PROT, 32'h0000_0001);
    rd_arr(12'hfc0, 8'hfc);
    rd_arr(12'hfc1, 8'h01);
    wr(OFF_MCR, 32'h0000_00f0);
    rd_arr(12'hfc1, 8'hff);
    special_mode_n <= 1'b1;
    do_reset();
    rd(OFF_DIVH);
    chk(rdat, 32'h0000_0000);
    rd(OFF_DIVL);
    chk(rdat, 32'h0000_0001);
    rd(OFF_MCR);
    chk(rdat, 32'h0000_00f0);
    chk(32'(debug_disable), 32'h0000_0001);
    $display("test shadow word done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
